//--- mioc_pkg.sv
// package: register map, field layout and codes of the motion i/o block
package mioc_pkg;
  // apb byte offsets
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_CURRENT = 8'h04;
  localparam logic [7:0] ADDR_TORQUE  = 8'h08;
  localparam logic [7:0] ADDR_IN_SET  = 8'h0c;
  localparam logic [7:0] ADDR_OUT_SET = 8'h10;
  localparam logic [7:0] ADDR_IN_WORD = 8'h14;
  localparam logic [7:0] ADDR_OUT_ONE = 8'h18;
  localparam logic [7:0] ADDR_OUT_TWO = 8'h1c;
  localparam logic [7:0] ADDR_OUT_WRD = 8'h20;
  localparam logic [7:0] ADDR_SIG_OUT = 8'h24;
  localparam logic [7:0] ADDR_ANALOG  = 8'h28;
  localparam logic [7:0] ADDR_STATUS  = 8'h2c;
  localparam logic [7:0] ADDR_TRIP_EN = 8'h30;
  // feedback modes
  localparam logic [1:0] MODE_BYPASS = 2'h0;
  localparam logic [1:0] MODE_FIXED  = 2'h1;
  localparam logic [1:0] MODE_VAR    = 2'h2;
  localparam logic [1:0] MODE_TORQUE = 2'h3;
  // input function codes
  localparam logic [4:0] IN_USER    = 5'h00;
  localparam logic [4:0] IN_JOG_NEG = 5'h08;
  localparam logic [4:0] IN_RESET   = 5'h0b;
  localparam logic [4:0] IN_CAPTURE = 5'h0c;
  // output function codes
  localparam logic [4:0] OUT_USER     = 5'h10;
  localparam logic [4:0] OUT_MOVING   = 5'h11;
  localparam logic [4:0] OUT_SW_ERR   = 5'h12;
  localparam logic [4:0] OUT_VEL_CHG  = 5'h14;
  localparam logic [4:0] OUT_LOCKED   = 5'h15;
  localparam logic [4:0] OUT_POS_CHG  = 5'h17;
  localparam logic [4:0] OUT_CL_ACT   = 5'h18;
  localparam logic [4:0] OUT_MAKEUP   = 5'h19;
  localparam logic [4:0] OUT_TRIP     = 5'h1c;
  // setup word fields: point [10:8], function [4:0], active/param bit 16
  localparam int SET_PT_LSB  = 8;
  localparam int SET_ACT_BIT = 16;
  localparam logic [2:0] PT_ANALOG = 3'h5;
  // reset values
  localparam logic [6:0] RUN_CUR_RST   = 7'h19;
  localparam logic [6:0] HOLD_CUR_RST  = 7'h05;
  localparam logic [6:0] TQ_PCT_RST    = 7'h19;
  localparam logic [15:0] TQ_SPD_RST   = 16'h0400;
  localparam logic [3:0] MAKEUP_DIV    = 4'h9;
  localparam int NUM_IN    = 4;
  localparam int NUM_OUT   = 3;
  localparam int NUM_TRIP  = 6;

  typedef struct packed {
    logic [4:0] func;
    logic       active_high;
  } mioc_setup_t;

  typedef struct packed {
    logic        moving;
    logic        sw_error;
    logic        vel_changing;
    logic        locked_rotor;
    logic        pos_changing;
  } mioc_motion_t;

  typedef enum logic [1:0] {
    MU_IDLE = 2'b01,
    MU_RUN  = 2'b10
  } mioc_mu_state_t;
endpackage

//--- mioc_top.sv
// motion i/o mapping and closed-loop mode control with apb registers
//
// Function
// - feedback mode 0 bypass, 1 fixed, 2 variable current, 3 torque
// - mode changes only while no move runs; host must not try
// - bypass skips closed loop; current fixed at run and hold level
// - bypass disables every encoder-dependent function
// - fixed mode compares encoder steps with commanded steps
// - lead/lag difference counted; make-up move corrects it when enabled
// - fixed mode drives bridge from run and hold settings
// - variable mode scales current to load, capped by run current
// - torque mode holds torque percent, speed capped by torque speed
// - without encoder only fixed run and hold current
// - inputs 1-4 take function codes 0-8 or 11, input 1 also 12 capture; polarity
// - each input readable as a flag and all four as a word; the code has no per-input read, flags come only in the ADDR_IN_WORD word
// - outputs 1-2 take codes 16-18, 20, 21, 23-25; polarity
// - outputs set one at a time or together as one coded word
// - analog input 12-bit counts; range 0 or 1 selectable
// - signal output code 28 asserts on any enabled trip event
// - signal output accepts codes 16-18, 20, 21, 23-25 with same polarity
// - signal output changed by trip event or direct set command
// - host is master; device executes, answers, reports, sets outputs
// - program mode bit only registered out on O_PROGRAM_MODE
`timescale 1ns/1ps
`default_nettype none
module mioc_top (
  input  wire logic                I_CLK_SYS,
  input  wire logic                I_RESET_N,
  input  wire logic                I_PSEL,
  input  wire logic                I_PENABLE,
  input  wire logic                I_PWRITE,
  input  wire logic [7:0]          I_PADDR,
  input  wire logic [31:0]         I_PWDATA,
  output logic [31:0]              O_PRDATA,
  output logic                     O_PREADY,
  output logic                     O_PSLVERR,
  input  wire logic [3:0]          I_IN_PIN,
  input  wire logic                I_ENC_PRESENT,
  input  wire mioc_pkg::mioc_motion_t I_MOTION,
  input  wire logic                I_CMD_STEP,
  input  wire logic                I_CMD_DIR,
  input  wire logic                I_ENC_STEP,
  input  wire logic                I_ENC_DIR,
  input  wire logic [6:0]          I_LOAD_DEMAND,
  input  wire logic [11:0]         I_ADC_DATA,
  input  wire logic                I_ADC_VALID,
  input  wire logic [5:0]          I_TRIP_EVENT,
  output logic [2:0]               O_OUT_PIN,
  output logic [12:0]              O_IN_FUNC,
  output logic [6:0]               O_BRIDGE_CURRENT,
  output logic [15:0]              O_SPEED_LIMIT,
  output logic                     O_CLOSED_LOOP,
  output logic                     O_MAKEUP_STEP,
  output logic                     O_MAKEUP_DIR,
  output logic                     O_ANALOG_RANGE,
  output logic                     O_PROGRAM_MODE
);

  ////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  logic [1:0] rst_sync_q;
  logic       rst_n;
  logic [3:0] in_meta_q;
  logic [3:0] in_sync_q;
  logic       enc_meta_q;
  logic       enc_sync_q;

  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      in_meta_q  <= 4'h0;
      in_sync_q  <= 4'h0;
      enc_meta_q <= 1'b0;
      enc_sync_q <= 1'b0;
    end else begin
      in_meta_q  <= I_IN_PIN;
      in_sync_q  <= in_meta_q;
      enc_meta_q <= I_ENC_PRESENT;
      enc_sync_q <= enc_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb decode
  logic        wr_en;
  logic        rd_en;
  logic [1:0]  mode_q;
  logic        addr_ok;
  logic [4:0]  wfunc;
  logic [2:0]  wpt;
  logic        wact;
  logic        mode_ok;
  logic        in_set_ok;
  logic        out_set_ok;
  logic        wr_reject;

  assign wr_en = I_PSEL && I_PENABLE && I_PWRITE;
  // read data is captured in the setup cycle and shown in the access
  assign rd_en = I_PSEL && !I_PENABLE && !I_PWRITE;
  assign wfunc = I_PWDATA[4:0];
  assign wpt   = I_PWDATA[mioc_pkg::SET_PT_LSB +: 3];
  assign wact  = I_PWDATA[mioc_pkg::SET_ACT_BIT];

  always_comb begin
    case (I_PADDR)
      mioc_pkg::ADDR_CTRL,    mioc_pkg::ADDR_CURRENT,
      mioc_pkg::ADDR_TORQUE,  mioc_pkg::ADDR_IN_SET,
      mioc_pkg::ADDR_OUT_SET, mioc_pkg::ADDR_IN_WORD,
      mioc_pkg::ADDR_OUT_ONE, mioc_pkg::ADDR_OUT_TWO,
      mioc_pkg::ADDR_OUT_WRD, mioc_pkg::ADDR_SIG_OUT,
      mioc_pkg::ADDR_ANALOG,  mioc_pkg::ADDR_STATUS,
      mioc_pkg::ADDR_TRIP_EN: addr_ok = 1'b1;
      default:                addr_ok = 1'b0;
    endcase
  end

  // undefined codes bounce with the old setting kept
  always_comb begin
    in_set_ok = 1'b0;
    if (wpt >= 3'h1 && wpt <= 3'h4) begin
      if (wfunc <= mioc_pkg::IN_JOG_NEG || wfunc == mioc_pkg::IN_RESET) begin
        in_set_ok = 1'b1;
      end
      if (wfunc == mioc_pkg::IN_CAPTURE && wpt == 3'h1) begin
        in_set_ok = 1'b1;
      end
    end else if (wpt == mioc_pkg::PT_ANALOG && wfunc == 5'h00) begin
      in_set_ok = 1'b1;
    end
    if (I_PWDATA[31:17] != 15'h0) begin
      in_set_ok = 1'b0;
    end
  end

  always_comb begin
    out_set_ok = 1'b0;
    if (wpt >= 3'h1 && wpt <= 3'h3) begin
      case (wfunc)
        mioc_pkg::OUT_USER,   mioc_pkg::OUT_MOVING, mioc_pkg::OUT_SW_ERR,
        mioc_pkg::OUT_VEL_CHG, mioc_pkg::OUT_LOCKED, mioc_pkg::OUT_POS_CHG,
        mioc_pkg::OUT_CL_ACT, mioc_pkg::OUT_MAKEUP:
          out_set_ok = 1'b1;
        mioc_pkg::OUT_TRIP: out_set_ok = (wpt == 3'h3);
        default:            out_set_ok = 1'b0;
      endcase
    end
    if (I_PWDATA[31:17] != 15'h0) begin
      out_set_ok = 1'b0;
    end
  end

  // mode change refused while a move runs or a make-up step pulse is out
  assign mode_ok = !I_MOTION.moving && !O_MAKEUP_STEP;

  always_comb begin
    wr_reject = 1'b0;
    case (I_PADDR)
      mioc_pkg::ADDR_CTRL:    wr_reject = !mode_ok &&
                                (I_PWDATA[1:0] != mode_q);
      mioc_pkg::ADDR_IN_SET:  wr_reject = !in_set_ok;
      mioc_pkg::ADDR_OUT_SET: wr_reject = !out_set_ok;
      default:                wr_reject = 1'b0;
    endcase
  end

  // zero wait states, error on unmapped address, refused setup or refused mode change
  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = I_PSEL && I_PENABLE &&
                     (!addr_ok || (I_PWRITE && wr_reject));

  ////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic        mu_en_q;
  logic        prog_q;
  logic [6:0]  run_cur_q;
  logic [6:0]  hold_cur_q;
  logic [6:0]  tq_pct_q;
  logic [15:0] tq_spd_q;
  logic        range_q;
  logic [5:0]  trip_en_q;
  logic        reject_q;
  mioc_pkg::mioc_setup_t in_set_q  [mioc_pkg::NUM_IN];
  mioc_pkg::mioc_setup_t out_set_q [mioc_pkg::NUM_OUT];

  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      mode_q     <= mioc_pkg::MODE_BYPASS;
      mu_en_q    <= 1'b0;
      prog_q     <= 1'b0;
      run_cur_q  <= mioc_pkg::RUN_CUR_RST;
      hold_cur_q <= mioc_pkg::HOLD_CUR_RST;
      tq_pct_q   <= mioc_pkg::TQ_PCT_RST;
      tq_spd_q   <= mioc_pkg::TQ_SPD_RST;
      range_q    <= 1'b0;
      trip_en_q  <= 6'h00;
    end else if (wr_en && !wr_reject) begin
      case (I_PADDR)
        mioc_pkg::ADDR_CTRL: begin
          mode_q  <= I_PWDATA[1:0];
          mu_en_q <= I_PWDATA[4];
          prog_q  <= I_PWDATA[8];
        end
        mioc_pkg::ADDR_CURRENT: begin
          run_cur_q  <= I_PWDATA[6:0];
          hold_cur_q <= I_PWDATA[14:8];
        end
        mioc_pkg::ADDR_TORQUE: begin
          tq_pct_q <= I_PWDATA[6:0];
          tq_spd_q <= I_PWDATA[31:16];
        end
        mioc_pkg::ADDR_IN_SET: begin
          if (wpt == mioc_pkg::PT_ANALOG) begin
            range_q <= wact;
          end
        end
        mioc_pkg::ADDR_TRIP_EN: trip_en_q <= I_PWDATA[5:0];
        default: ;
      endcase
    end
  end

  // refused-write flag: a fresh refusal wins over the clearing write
  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      reject_q <= 1'b0;
    end else if (wr_en && wr_reject) begin
      reject_q <= 1'b1;
    end else if (wr_en && I_PADDR == mioc_pkg::ADDR_STATUS) begin
      reject_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // inputs: per point setup and function decode
  logic [3:0] in_state;
  logic [12:0] func_hits [mioc_pkg::NUM_IN];

  genvar gi;
  generate
    for (gi = 0; gi < mioc_pkg::NUM_IN; gi++) begin : g_in
      always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
          in_set_q[gi] <= '{func: mioc_pkg::IN_USER, active_high: 1'b1};
        end else if (wr_en && !wr_reject &&
                     I_PADDR == mioc_pkg::ADDR_IN_SET &&
                     wpt == 3'(gi + 1)) begin
          in_set_q[gi] <= '{func: wfunc, active_high: wact};
        end
      end
      // polarity folds the pin into a logic-true state
      assign in_state[gi] = in_sync_q[gi] ~^ in_set_q[gi].active_high;
      always_comb begin
        func_hits[gi] = 13'h0000;
        func_hits[gi][in_set_q[gi].func[3:0]] = in_state[gi];
      end
    end
  endgenerate

  // function lines leave on a flop, one cycle after the state
  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      O_IN_FUNC <= 13'h0000;
    end else begin
      O_IN_FUNC <= func_hits[0] | func_hits[1] | func_hits[2] |
                   func_hits[3];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // closed loop: lead/lag counter and make-up move
  logic                     cl_active;
  logic signed [15:0]       lag_q;
  logic                     mu_step;
  logic [3:0]               mu_div_q;
  mioc_pkg::mioc_mu_state_t mu_state_q;

  // encoder work only with encoder and mode above bypass
  assign cl_active = enc_sync_q && (mode_q != mioc_pkg::MODE_BYPASS);
  assign mu_step   = (mu_state_q == mioc_pkg::MU_RUN) && (mu_div_q == 4'h0);

  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      lag_q <= 16'sh0000;
    end else if (!cl_active) begin
      lag_q <= 16'sh0000;
    end else begin
      // commanded minus actual, make-up steps pull it to zero
      lag_q <= lag_q
             + ((I_CMD_STEP) ? (I_CMD_DIR ? 16'sh0001 : -16'sh0001)
                             : 16'sh0000)
             - ((I_ENC_STEP) ? (I_ENC_DIR ? 16'sh0001 : -16'sh0001)
                             : 16'sh0000)
             - ((mu_step) ? (lag_q[15] ? -16'sh0001 : 16'sh0001)
                          : 16'sh0000);
    end
  end

  // correction runs only after the move, paced by a divider
  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      mu_state_q <= mioc_pkg::MU_IDLE;
      mu_div_q   <= mioc_pkg::MAKEUP_DIV;
    end else begin
      case (mu_state_q)
        mioc_pkg::MU_IDLE: begin
          mu_div_q <= mioc_pkg::MAKEUP_DIV;
          if (cl_active && mu_en_q && !I_MOTION.moving &&
              lag_q != 16'sh0000) begin
            mu_state_q <= mioc_pkg::MU_RUN;
          end
        end
        mioc_pkg::MU_RUN: begin
          mu_div_q <= (mu_div_q == 4'h0) ? mioc_pkg::MAKEUP_DIV
                                         : mu_div_q - 4'h1;
          if (!cl_active || !mu_en_q || I_MOTION.moving ||
              lag_q == 16'sh0000) begin
            mu_state_q <= mioc_pkg::MU_IDLE;
          end
        end
        default: mu_state_q <= mioc_pkg::MU_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      O_MAKEUP_STEP <= 1'b0;
      O_MAKEUP_DIR  <= 1'b0;
    end else begin
      O_MAKEUP_STEP <= mu_step;
      O_MAKEUP_DIR  <= !lag_q[15];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bridge current and speed limit per mode
  logic [6:0] fixed_cur;
  logic [6:0] cur_d;
  logic [15:0] spd_d;

  // bypass and fixed use run/hold alone
  assign fixed_cur = I_MOTION.moving ? run_cur_q : hold_cur_q;

  always_comb begin
    cur_d = fixed_cur;
    spd_d = 16'hffff;
    if (cl_active) begin
      case (mode_q)
        mioc_pkg::MODE_VAR: begin
          // load demand capped at run current
          cur_d = (I_LOAD_DEMAND > run_cur_q) ? run_cur_q : I_LOAD_DEMAND;
        end
        mioc_pkg::MODE_TORQUE: begin
          cur_d = tq_pct_q;
          spd_d = tq_spd_q;
        end
        default: cur_d = fixed_cur;
      endcase
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      O_BRIDGE_CURRENT <= 7'h00;
      O_SPEED_LIMIT    <= 16'hffff;
      O_CLOSED_LOOP    <= 1'b0;
    end else begin
      O_BRIDGE_CURRENT <= cur_d;
      O_SPEED_LIMIT    <= spd_d;
      O_CLOSED_LOOP    <= cl_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs 1-2 and signal output 3
  logic [2:0] user_q;
  logic [2:0] out_val;
  logic       trip_hit;

  assign trip_hit = |(I_TRIP_EVENT & trip_en_q);

  // user bits: single, word or trip writes; a trip wins the same cycle
  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      user_q <= 3'h0;
    end else begin
      if (wr_en) begin
        case (I_PADDR)
          mioc_pkg::ADDR_OUT_ONE: user_q[0]   <= I_PWDATA[0];
          mioc_pkg::ADDR_OUT_TWO: user_q[1]   <= I_PWDATA[0];
          mioc_pkg::ADDR_OUT_WRD: user_q[1:0] <= I_PWDATA[1:0];
          mioc_pkg::ADDR_SIG_OUT: user_q[2]   <= I_PWDATA[0];
          default: ;
        endcase
      end
      if (trip_hit && out_set_q[2].func == mioc_pkg::OUT_TRIP) begin
        user_q[2] <= 1'b1;
      end
    end
  end

  genvar go;
  generate
    for (go = 0; go < mioc_pkg::NUM_OUT; go++) begin : g_out
      always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
          out_set_q[go] <= '{func: mioc_pkg::OUT_USER, active_high: 1'b1};
        end else if (wr_en && !wr_reject &&
                     I_PADDR == mioc_pkg::ADDR_OUT_SET &&
                     wpt == 3'(go + 1)) begin
          out_set_q[go] <= '{func: wfunc, active_high: wact};
        end
      end
      always_comb begin
        case (out_set_q[go].func)
          mioc_pkg::OUT_MOVING:  out_val[go] = I_MOTION.moving;
          mioc_pkg::OUT_SW_ERR:  out_val[go] = I_MOTION.sw_error;
          mioc_pkg::OUT_VEL_CHG: out_val[go] = I_MOTION.vel_changing;
          mioc_pkg::OUT_LOCKED:  out_val[go] = I_MOTION.locked_rotor &&
                                               cl_active;
          mioc_pkg::OUT_POS_CHG: out_val[go] = I_MOTION.pos_changing;
          mioc_pkg::OUT_CL_ACT:  out_val[go] = cl_active;
          mioc_pkg::OUT_MAKEUP:  out_val[go] = mu_state_q ==
                                               mioc_pkg::MU_RUN;
          default:               out_val[go] = user_q[go];
        endcase
      end
      // polarity applied at the pin
      always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
          O_OUT_PIN[go] <= 1'b0;
        end else begin
          O_OUT_PIN[go] <= out_val[go] ~^ out_set_q[go].active_high;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // analog sample
  logic [11:0] adc_q;

  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      adc_q <= 12'h000;
    end else if (I_ADC_VALID) begin
      adc_q <= I_ADC_DATA;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      O_ANALOG_RANGE <= 1'b0;
      O_PROGRAM_MODE <= 1'b0;
    end else begin
      O_ANALOG_RANGE <= range_q;
      O_PROGRAM_MODE <= prog_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux, held in a flop so prdata stays stable
  logic [31:0] rd_d;

  always_comb begin
    rd_d = 32'h0000_0000;
    case (I_PADDR)
      mioc_pkg::ADDR_CTRL:    rd_d = {23'h0, prog_q, 3'h0, mu_en_q,
                                      2'h0, mode_q};
      mioc_pkg::ADDR_CURRENT: rd_d = {17'h0, hold_cur_q, 1'b0, run_cur_q};
      mioc_pkg::ADDR_TORQUE:  rd_d = {tq_spd_q, 9'h0, tq_pct_q};
      mioc_pkg::ADDR_IN_SET:  rd_d = {15'h0, range_q, 16'h0};
      // flags in bits 3:0, same word mirrored in 11:8
      mioc_pkg::ADDR_IN_WORD: rd_d = {20'h0, in_state, 4'h0, in_state};
      mioc_pkg::ADDR_OUT_ONE: rd_d = {31'h0, user_q[0]};
      mioc_pkg::ADDR_OUT_TWO: rd_d = {31'h0, user_q[1]};
      mioc_pkg::ADDR_OUT_WRD: rd_d = {29'h0, O_OUT_PIN};
      mioc_pkg::ADDR_SIG_OUT: rd_d = {31'h0, user_q[2]};
      mioc_pkg::ADDR_ANALOG:  rd_d = {20'h0, adc_q};
      mioc_pkg::ADDR_STATUS:  rd_d = {lag_q, 12'h0, reject_q,
                                      mu_state_q == mioc_pkg::MU_RUN,
                                      cl_active, enc_sync_q};
      mioc_pkg::ADDR_TRIP_EN: rd_d = {26'h0, trip_en_q};
      default:                rd_d = 32'h0000_0000;
    endcase
  end

  // zero outside a read access, so stale data never leaks
  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      O_PRDATA <= 32'h0000_0000;
    end else if (rd_en) begin
      O_PRDATA <= rd_d;
    end else begin
      O_PRDATA <= 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire

//--- mioc_chk.sv
// checker: port-level properties of the motion i/o block
`timescale 1ns/1ps
`default_nettype none
module mioc_chk (
  input wire logic        I_CLK_SYS,
  input wire logic        I_RESET_N,
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        I_PWRITE,
  input wire logic [7:0]  I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic        O_PREADY,
  input wire logic        O_PSLVERR,
  input wire logic [12:0] O_IN_FUNC,
  input wire logic        O_CLOSED_LOOP,
  input wire logic        O_MAKEUP_STEP
);
  logic acc;
  logic setw;
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESET_N);
  assign acc = I_PSEL && I_PENABLE;
  assign setw = acc && I_PWRITE && (I_PADDR == mioc_pkg::ADDR_IN_SET
    || I_PADDR == mioc_pkg::ADDR_OUT_SET);
  ////////////////////////////////////////////////////////////////////////
  a_ready_high: assert property (O_PREADY)
    else $error("pready dropped");
  a_idle_zero: assert property (
    !(acc && !I_PWRITE) |-> O_PRDATA == 32'h0) else $error("stray data");
  a_unmapped_err: assert property (
    acc && I_PADDR > 8'h30 |-> O_PSLVERR) else $error("no error");
  a_unmapped_zero: assert property (
    acc && !I_PWRITE && I_PADDR > 8'h30 |-> O_PRDATA == 32'h0)
    else $error("unmapped data");
  a_setup_refused: assert property (
    setw && (I_PWDATA[31:17] != 15'h0 || I_PWDATA[10:8] == 3'h0)
    |-> O_PSLVERR) else $error("bad setup taken");
  // registered loop flag may lag the mode write by one cycle
  a_bypass_open: assert property (
    acc && I_PWRITE && !O_PSLVERR && I_PADDR == mioc_pkg::ADDR_CTRL
    && I_PWDATA[1:0] == mioc_pkg::MODE_BYPASS |-> ##[1:2] !O_CLOSED_LOOP)
    else $error("loop still closed");
  a_makeup_pace: assert property (
    O_MAKEUP_STEP |=> !O_MAKEUP_STEP [*8]) else $error("steps too close");
  a_func_gap: assert property (
    O_IN_FUNC[10:9] == 2'b00) else $error("undefined function");
endmodule
bind mioc_top mioc_chk u_chk (.I_CLK_SYS, .I_RESET_N, .I_PSEL, .I_PENABLE,
  .I_PWRITE, .I_PADDR, .I_PWDATA, .O_PRDATA, .O_PREADY, .O_PSLVERR,
  .O_IN_FUNC, .O_CLOSED_LOOP, .O_MAKEUP_STEP);
`default_nettype wire

//--- mioc_host.sv
// host model: apb master standing in for the commanding host
`timescale 1ns/1ps
`default_nettype none
module mioc_host (
  input  wire logic        clk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output logic             psel = 1'b0,
  output logic             penable = 1'b0,
  output logic             pwrite = 1'b0,
  output logic [7:0]       paddr = 8'h0,
  output logic [31:0]      pwdata = 32'h0
);
  // host leads every exchange; device only answers
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e,
      output logic t);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    t = (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines must not keep a stale copy
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

//--- motion_io_mode_config_test.sv
// testbench: apb-driven checks of the motion i/o block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  fail_count++; $display("unexpected %0t: %h", $time, g); end end
module motion_io_mode_config_test;
  logic                   clk = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   psel, penable, pwrite, pready, pslverr;
  logic [7:0]             paddr;
  logic [31:0]            pwdata, prdata, q;
  logic [3:0]             pin = 4'h0;
  logic                   enc = 1'b0, cst = 1'b0, est = 1'b0, av = 1'b0;
  mioc_pkg::mioc_motion_t mot = '0;
  logic [6:0]             dem = 7'h0, cur;
  logic [11:0]            adc = 12'h0;
  logic [5:0]             trip = 6'h0;
  logic [2:0]             opin;
  logic [12:0]            ifn;
  logic [15:0]            spd;
  logic                   cl, mst, mdir, arg, pm;
  int                     n, fail_count = 0, samples_checked = 0;
  always #25 clk = ~clk;
  mioc_host host (.clk(clk), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  mioc_top uut (.I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_IN_PIN(pin), .I_ENC_PRESENT(enc),
    .I_MOTION(mot), .I_CMD_STEP(cst), .I_CMD_DIR(1'b1), .I_ENC_STEP(est),
    .I_ENC_DIR(1'b1), .I_LOAD_DEMAND(dem), .I_ADC_DATA(adc),
    .I_ADC_VALID(av), .I_TRIP_EVENT(trip), .O_OUT_PIN(opin),
    .O_IN_FUNC(ifn), .O_BRIDGE_CURRENT(cur), .O_SPEED_LIMIT(spd),
    .O_CLOSED_LOOP(cl), .O_MAKEUP_STEP(mst), .O_MAKEUP_DIR(mdir),
    .O_ANALOG_RANGE(arg), .O_PROGRAM_MODE(pm));
  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checked %0d failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask
  // every access also checks the error answer
  task automatic rw(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic e);
    logic r, t;
    host.xfer(w, a, d, q, r, t);
    `CHK(r, e)
    if (t) begin
      fail_count++;
      complete_run();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(16);
    rst_n <= 1'b1;
    cyc(3);
    rw(0, mioc_pkg::ADDR_CURRENT, 0, 0);
    `CHK(q, 32'h0000_0519)
    `CHK(cur, 7'h05)
    mot.moving <= 1'b1;
    cyc(3);
    `CHK(cur, 7'h19)
    rw(1, mioc_pkg::ADDR_CTRL, 2, 1);
    mot.moving <= 1'b0;
    enc <= 1'b1;
    cyc(4);
    rw(1, mioc_pkg::ADDR_CTRL, 2, 0);
    dem <= 7'h0a;
    cyc(3);
    `CHK(cur, 7'h0a)
    dem <= 7'h50;
    cyc(3);
    `CHK(cur, 7'h19)
    rw(1, mioc_pkg::ADDR_CTRL, 3, 0);
    cyc(3);
    `CHK(spd, 16'h0400)
    enc <= 1'b0;
    cyc(5);
    `CHK(cur, 7'h05)
    enc <= 1'b1;
    cyc(4);
    rw(1, mioc_pkg::ADDR_CTRL, 1, 0);
    cyc(3);
    `CHK(cl, 1'b1)
    mot.moving <= 1'b1;
    repeat (3) begin
      cst <= 1'b1;
      cyc(1);
      cst <= 1'b0;
      cyc(1);
    end
    est <= 1'b1;
    cyc(1);
    est <= 1'b0;
    cyc(3);
    rw(0, mioc_pkg::ADDR_STATUS, 0, 0);
    `CHK(q[31:16], 16'h0002)
    rw(1, mioc_pkg::ADDR_CTRL, 32'h11, 0);
    mot.moving <= 1'b0;
    n = 0;
    repeat (40) begin
      cyc(1);
      n += int'(mst === 1'b1);
      if (mst === 1'b1) `CHK(mdir, 1'b1)
    end
    `CHK(n, 2)
    rw(1, mioc_pkg::ADDR_IN_SET, 32'h0001_0107, 0);
    rw(1, mioc_pkg::ADDR_IN_SET, 32'h0000_0201, 0);
    pin <= 4'h1;
    cyc(4);
    `CHK(ifn, 13'h0082)
    rw(0, mioc_pkg::ADDR_IN_WORD, 0, 0);
    `CHK(q[3:0], 4'h3)
    for (int k = 0; k < 13; k++) begin
      rw(1, mioc_pkg::ADDR_IN_SET, 32'h100 | k, k == 9 || k == 10);
    end
    rw(1, mioc_pkg::ADDR_IN_SET, 32'h0002_0600, 1);
    for (int p = 2; p < 4; p++) begin
      for (int k = 16; k < 29; k++) begin
        rw(1, mioc_pkg::ADDR_OUT_SET, 32'h10000 | p << 8 | k, k == 19 ||
          k == 22 || (k > 25 && (p == 2 || k != 28)));
      end
    end
    rw(1, mioc_pkg::ADDR_OUT_SET, 32'h0001_0210, 0);
    rw(1, mioc_pkg::ADDR_OUT_WRD, 2, 0);
    cyc(2);
    `CHK(opin, 3'b010)
    rw(1, mioc_pkg::ADDR_TRIP_EN, 32'h3f, 0);
    trip <= 6'h04;
    cyc(1);
    trip <= 6'h00;
    cyc(3);
    `CHK(opin[2], 1'b1)
    rw(1, mioc_pkg::ADDR_SIG_OUT, 0, 0);
    cyc(2);
    `CHK(opin[2], 1'b0)
    rw(1, mioc_pkg::ADDR_IN_SET, 32'h0001_0500, 0);
    adc <= 12'habc;
    av <= 1'b1;
    cyc(1);
    av <= 1'b0;
    cyc(2);
    `CHK(arg, 1'b1)
    rw(0, mioc_pkg::ADDR_ANALOG, 0, 0);
    `CHK(q, 32'h0000_0abc)
    rw(0, 8'h34, 0, 1);
    rw(1, mioc_pkg::ADDR_CTRL, 32'h100, 0);
    cyc(3);
    `CHK(cl, 1'b0)
    `CHK(pm, 1'b1)
    complete_run();
  end
endmodule
`default_nettype wire
